/* design/zcd_pkg.sv */
// constants, register map and field layout for the zero-cross detector logic
package zcd_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int DEC_W = 8;

	// byte offsets of the registers
	localparam logic [DEC_W-1:0] CTRL_OFF = 8'h00;
	localparam logic [DEC_W-1:0] FLAG_OFF = 8'h04;
	localparam logic [DEC_W-1:0] IRQEN_OFF = 8'h08;
	localparam logic [DEC_W-1:0] IRQCTL_OFF = 8'h0c;
	localparam logic [DEC_W-1:0] STATUS_OFF = 8'h10;

	// control register fields
	localparam int DET_EN_BIT = 7;
	localparam int PIN_OE_BIT = 6;
	localparam int LEVEL_BIT = 5;
	localparam int INVERT_BIT = 4;
	localparam int RISE_EN_BIT = 1;
	localparam int FALL_EN_BIT = 0;

	// flag, mask and irq control fields
	localparam int CROSS_BIT = 0;
	localparam int PERIPH_EN_BIT = 0;
	localparam int GLOBAL_EN_BIT = 1;

	// status register fields
	localparam int SLEEP_BIT = 0;
	localparam int ACTIVE_BIT = 1;

	// reset values
	localparam logic RESET_LOW = 1'b0;
	localparam logic READY_IDLE = 1'b1;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

	// htrans encoding and response
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
endpackage

/* design/crossing_if.sv */
// carries the raw sink decision into the synchroniser and the clean level back
`timescale 1ns/1ps
interface crossing_if;
	logic analogSink;
	logic syncSink;

	modport sampler (
		input analogSink,
		output syncSink
	);
	modport owner (
		output analogSink,
		input syncSink
	);
endinterface

/* design/zcd_sync.sv */
// two-stage synchroniser for the analog sink decision
`timescale 1ns/1ps
module zcd_sync (
	input wire logic sys_clk,
	input wire logic reset,
	crossing_if.sampler link
);
	import zcd_pkg::*;

	logic meta_ff;
	logic stable_ff;
	logic nxt_meta;
	logic nxt_stable;

	always_comb begin
		nxt_meta = link.analogSink;
		nxt_stable = meta_ff;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_ff <= RESET_LOW;
			stable_ff <= RESET_LOW;
		end else begin
			meta_ff <= nxt_meta;
			stable_ff <= nxt_stable;
		end
	end

	assign link.syncSink = stable_ff;
endmodule

/* design/zcd_logic.sv */
// zero-cross detector digital side with AHB-Lite register slave
`timescale 1ns/1ps
module zcd_logic (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [zcd_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [zcd_pkg::DATA_W-1:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [zcd_pkg::DATA_W-1:0] hrdata,
	input wire logic analogSink,
	input wire logic sleepMode,
	input wire logic porDetectorDefaultN,
	output logic stageEnable,
	output logic pinOut,
	output logic pinOe,
	output logic cpuIrq
);
	import zcd_pkg::*;

	function automatic logic hitReg(input logic [DEC_W-1:0] addr, input logic [DEC_W-1:0] off);
		hitReg = (addr == off);
	endfunction

	crossing_if crossing ();

	assign crossing.analogSink = analogSink;

	zcd_sync syncer (
		.sys_clk(sys_clk),
		.reset(reset),
		.link(crossing)
	);

	// bus state
	logic wrPend_ff;
	logic rdPend_ff;
	logic [DEC_W-1:0] addr_ff;
	logic hreadyout_ff;
	logic [DATA_W-1:0] hrdata_ff;
	logic nxt_wrPend;
	logic nxt_rdPend;
	logic [DEC_W-1:0] nxt_addr;
	logic nxt_hreadyout;
	logic [DATA_W-1:0] nxt_hrdata;

	// software-visible state
	logic detEn_ff;
	logic pinOeCfg_ff;
	logic invert_ff;
	logic riseEn_ff;
	logic fallEn_ff;
	logic crossFlag_ff;
	logic crossIe_ff;
	logic periphIe_ff;
	logic globalIe_ff;
	logic nxt_detEn;
	logic nxt_pinOeCfg;
	logic nxt_invert;
	logic nxt_riseEn;
	logic nxt_fallEn;
	logic nxt_crossFlag;
	logic nxt_crossIe;
	logic nxt_periphIe;
	logic nxt_globalIe;

	// crossing state and outputs
	logic level_ff;
	logic prevLevel_ff;
	logic stageEnable_ff;
	logic pinOut_ff;
	logic pinOe_ff;
	logic cpuIrq_ff;
	logic nxt_level;
	logic nxt_prevLevel;
	logic nxt_pinOut;
	logic nxt_pinOe;
	logic nxt_cpuIrq;

	logic accept;
	logic wrCtrl;
	logic wrFlag;
	logic wrIrqEn;
	logic wrIrqCtl;
	logic riseEdge;
	logic fallEdge;
	logic setEvent;
	logic [DATA_W-1:0] readWord;

	always_comb begin
		accept = hsel && hready && (htrans == HTRANS_NONSEQ);
		wrCtrl = wrPend_ff && hitReg(addr_ff, CTRL_OFF);
		wrFlag = wrPend_ff && hitReg(addr_ff, FLAG_OFF);
		wrIrqEn = wrPend_ff && hitReg(addr_ff, IRQEN_OFF);
		wrIrqCtl = wrPend_ff && hitReg(addr_ff, IRQCTL_OFF);
	end

	// read multiplexer, unmapped words read as zero
	always_comb begin
		readWord = '0;
		if (hitReg(addr_ff, CTRL_OFF)) begin
			readWord[DET_EN_BIT] = detEn_ff;
			readWord[PIN_OE_BIT] = pinOeCfg_ff;
			readWord[LEVEL_BIT] = level_ff;
			readWord[INVERT_BIT] = invert_ff;
			readWord[RISE_EN_BIT] = riseEn_ff;
			readWord[FALL_EN_BIT] = fallEn_ff;
		end else if (hitReg(addr_ff, FLAG_OFF)) begin
			readWord[CROSS_BIT] = crossFlag_ff;
		end else if (hitReg(addr_ff, IRQEN_OFF)) begin
			readWord[CROSS_BIT] = crossIe_ff;
		end else if (hitReg(addr_ff, IRQCTL_OFF)) begin
			readWord[PERIPH_EN_BIT] = periphIe_ff;
			readWord[GLOBAL_EN_BIT] = globalIe_ff;
		end else if (hitReg(addr_ff, STATUS_OFF)) begin
			readWord[SLEEP_BIT] = sleepMode;
			readWord[ACTIVE_BIT] = stageEnable_ff;
		end
	end

	// bus slave: writes take no wait, reads take one wait state for fresh data
	always_comb begin
		nxt_wrPend = accept && hwrite;
		nxt_rdPend = accept && !hwrite;
		nxt_addr = accept ? haddr[DEC_W-1:0] : addr_ff;
		nxt_hreadyout = !(accept && !hwrite);
		nxt_hrdata = rdPend_ff ? readWord : hrdata_ff;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wrPend_ff <= RESET_LOW;
			rdPend_ff <= RESET_LOW;
			addr_ff <= '0;
			hreadyout_ff <= READY_IDLE;
			hrdata_ff <= RDATA_RESET;
		end else begin
			wrPend_ff <= nxt_wrPend;
			rdPend_ff <= nxt_rdPend;
			addr_ff <= nxt_addr;
			hreadyout_ff <= nxt_hreadyout;
			hrdata_ff <= nxt_hrdata;
		end
	end

	// level flag, edge detectors and interrupt path; no sleep gating anywhere
	always_comb begin
		// gated sink decision, then polarity
		nxt_level = (crossing.syncSink && detEn_ff) ^ invert_ff;
		nxt_prevLevel = level_ff;
		riseEdge = level_ff && !prevLevel_ff;
		fallEdge = !level_ff && prevLevel_ff;
		// an invert change flips level_ff even with the stage off
		setEvent = (riseEdge && riseEn_ff) || (fallEdge && fallEn_ff);
		nxt_crossFlag = crossFlag_ff;
		if (wrFlag && hwdata[CROSS_BIT]) begin
			nxt_crossFlag = 1'b0;
		end
		if (setEvent) begin
			nxt_crossFlag = 1'b1;
		end
		nxt_cpuIrq = nxt_crossFlag && crossIe_ff && periphIe_ff && globalIe_ff;
		nxt_pinOut = nxt_level && nxt_pinOeCfg;
		nxt_pinOe = nxt_pinOeCfg;
	end

	// register writes
	always_comb begin
		nxt_detEn = detEn_ff;
		nxt_pinOeCfg = pinOeCfg_ff;
		nxt_invert = invert_ff;
		nxt_riseEn = riseEn_ff;
		nxt_fallEn = fallEn_ff;
		nxt_crossIe = crossIe_ff;
		nxt_periphIe = periphIe_ff;
		nxt_globalIe = globalIe_ff;
		if (wrCtrl) begin
			nxt_detEn = hwdata[DET_EN_BIT];
			nxt_pinOeCfg = hwdata[PIN_OE_BIT];
			nxt_invert = hwdata[INVERT_BIT];
			nxt_riseEn = hwdata[RISE_EN_BIT];
			nxt_fallEn = hwdata[FALL_EN_BIT];
		end
		if (wrIrqEn) begin
			nxt_crossIe = hwdata[CROSS_BIT];
		end
		if (wrIrqCtl) begin
			nxt_periphIe = hwdata[PERIPH_EN_BIT];
			nxt_globalIe = hwdata[GLOBAL_EN_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			// fuse is sampled while the synchronous reset is held
			detEn_ff <= !porDetectorDefaultN;
			pinOeCfg_ff <= RESET_LOW;
			invert_ff <= RESET_LOW;
			riseEn_ff <= RESET_LOW;
			fallEn_ff <= RESET_LOW;
			crossFlag_ff <= RESET_LOW;
			crossIe_ff <= RESET_LOW;
			periphIe_ff <= RESET_LOW;
			globalIe_ff <= RESET_LOW;
			level_ff <= RESET_LOW;
			prevLevel_ff <= RESET_LOW;
			stageEnable_ff <= RESET_LOW;
			pinOut_ff <= RESET_LOW;
			pinOe_ff <= RESET_LOW;
			cpuIrq_ff <= RESET_LOW;
		end else begin
			detEn_ff <= nxt_detEn;
			pinOeCfg_ff <= nxt_pinOeCfg;
			invert_ff <= nxt_invert;
			riseEn_ff <= nxt_riseEn;
			fallEn_ff <= nxt_fallEn;
			crossFlag_ff <= nxt_crossFlag;
			crossIe_ff <= nxt_crossIe;
			periphIe_ff <= nxt_periphIe;
			globalIe_ff <= nxt_globalIe;
			level_ff <= nxt_level;
			prevLevel_ff <= nxt_prevLevel;
			stageEnable_ff <= nxt_detEn;
			pinOut_ff <= nxt_pinOut;
			pinOe_ff <= nxt_pinOe;
			cpuIrq_ff <= nxt_cpuIrq;
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hresp = HRESP_OKAY;
	assign hrdata = hrdata_ff;
	assign stageEnable = stageEnable_ff;
	assign pinOut = pinOut_ff;
	assign pinOe = pinOe_ff;
	assign cpuIrq = cpuIrq_ff;
endmodule

/* tb/zcd_ac_source.sv */
// behavioural ac source whose sink decision follows the commanded side of the reference
`timescale 1ns/1ps
module zcd_ac_source (
	input wire logic aboveRef,
	output logic analogSink
);
	initial begin
		analogSink = 1'b0;
	end
	// skew keeps changes off the clock edge, as a real analog decision would be
	always @(aboveRef) begin
		analogSink <= #7 aboveRef;
	end
endmodule

/* tb/zcd_logic_assertions.sv */
// concurrent checks on the zero-cross detector ports
`timescale 1ns/1ps
module zcd_logic_assertions (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic porDetectorDefaultN,
	input wire logic stageEnable,
	input wire logic pinOut,
	input wire logic pinOe,
	input wire logic cpuIrq
);
	import zcd_pkg::*;
	logic wr1_ff, wr2_ff, wasReset_ff, fuseClear_ff;
	logic nxt_wr1, nxt_fuseClear;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence readTaken;
		hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence writeTaken;
		hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
	endsequence
	always_comb begin
		nxt_wr1 = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
		nxt_fuseClear = reset ? !porDetectorDefaultN : fuseClear_ff;
	end
	always_ff @(posedge sys_clk) begin
		wr1_ff <= nxt_wr1;
		wr2_ff <= wr1_ff;
		wasReset_ff <= reset;
		fuseClear_ff <= nxt_fuseClear;
	end
	a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("bad hresp");
	a_read_wait: assert property (readTaken |=> !hreadyout ##1 hreadyout) else $error("read wait");
	a_write_nowait: assert property (writeTaken |=> hreadyout) else $error("write wait");
	a_pin_gate: assert property (!pinOe |-> !pinOut) else $error("pin driven");
	a_irq_cleared: assert property ($fell(cpuIrq) |-> wr2_ff) else $error("irq fell");
	a_detector_off: assert property ($fell(stageEnable) |-> wr1_ff || wr2_ff)
		else $error("stage fell");
	a_fuse_active: assert property (wasReset_ff && fuseClear_ff |=> stageEnable)
		else $error("fuse default");
	a_reset_quiet: assert property (wasReset_ff |-> !cpuIrq && !pinOe && !stageEnable)
		else $error("reset state");
endmodule
bind zcd_logic zcd_logic_assertions i_zcd_logic_assertions (
	.sys_clk(sys_clk),
	.reset(reset),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.porDetectorDefaultN(porDetectorDefaultN),
	.stageEnable(stageEnable),
	.pinOut(pinOut),
	.pinOe(pinOe),
	.cpuIrq(cpuIrq)
);

/* tb/zcd_logic_tb_top.sv */
// self-checking bench for the zero-cross detector logic
`timescale 1ns/1ps
module zcd_logic_tb_top;
	import zcd_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [ADDR_W-1:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [DATA_W-1:0] hwdata = 32'h0;
	logic [DATA_W-1:0] hrdata;
	logic hreadyout, hresp, stageEnable, pinOut, pinOe, cpuIrq, analogSink;
	logic aboveRef = 1'b0;
	logic sleepMode = 1'b0;
	logic fuseN = 1'b0;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	zcd_logic i_zcd_logic (
		.sys_clk(sys_clk),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(3'h2),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.analogSink(analogSink),
		.sleepMode(sleepMode),
		.porDetectorDefaultN(fuseN),
		.stageEnable(stageEnable),
		.pinOut(pinOut),
		.pinOe(pinOe),
		.cpuIrq(cpuIrq)
	);
	zcd_ac_source i_zcd_ac_source (.aboveRef(aboveRef), .analogSink(analogSink));
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// a read compares the returned word with d
	task automatic rw(input int w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= (w != 0);
		haddr <= {24'h0, a};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= (w != 0) ? d : 32'h0;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		if (w == 0) chk($sformatf("reg %h", a), hrdata, d);
		#1;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("stage", {31'h0, stageEnable}, 32'h1);
		rw(0, STATUS_OFF, 32'h2);
		rw(1, CTRL_OFF, 32'hc3);
		aboveRef <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rw(0, CTRL_OFF, 32'he3);
		chk("pin", {30'h0, pinOe, pinOut}, 32'h3);
		rw(0, FLAG_OFF, 32'h1);
		rw(1, IRQEN_OFF, 32'h1);
		rw(1, IRQCTL_OFF, 32'h1);
		chk("irq", {31'h0, cpuIrq}, 32'h0);
		rw(1, IRQCTL_OFF, 32'h3);
		// the irq output follows new enables one edge after the write lands
		@(posedge sys_clk);
		#1;
		chk("irq", {31'h0, cpuIrq}, 32'h1);
		rw(1, FLAG_OFF, 32'h1);
		chk("irq", {31'h0, cpuIrq}, 32'h0);
		$display("end level test");
		rw(1, CTRL_OFF, 32'hd3);
		repeat (3) @(posedge sys_clk);
		rw(0, CTRL_OFF, 32'hd3);
		rw(0, FLAG_OFF, 32'h1);
		rw(1, FLAG_OFF, 32'h1);
		rw(1, CTRL_OFF, 32'h01);
		rw(1, CTRL_OFF, 32'h11);
		repeat (3) @(posedge sys_clk);
		rw(0, FLAG_OFF, 32'h0);
		rw(1, CTRL_OFF, 32'h01);
		repeat (3) @(posedge sys_clk);
		rw(0, FLAG_OFF, 32'h1);
		rw(1, FLAG_OFF, 32'h1);
		$display("end invert test");
		sleepMode <= 1'b1;
		rw(1, CTRL_OFF, 32'hc3);
		repeat (4) @(posedge sys_clk);
		rw(1, FLAG_OFF, 32'h1);
		aboveRef <= 1'b0;
		// the clear lands in the very cycle the falling edge is detected
		@(posedge sys_clk);
		rw(1, FLAG_OFF, 32'h1);
		repeat (8) @(posedge sys_clk);
		rw(0, FLAG_OFF, 32'h1);
		rw(0, STATUS_OFF, 32'h3);
		rw(1, 8'h20, 32'hff);
		rw(0, 8'h20, 32'h0);
		$display("end sleep test");
		fuseN <= 1'b1;
		reset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("stage", {31'h0, stageEnable}, 32'h0);
		rw(0, CTRL_OFF, 32'h0);
		$display("end fuse test");
		finish_test();
	end
endmodule
